// [gpc_cfg.svh]
// Named constants of the three-bit port: register map, field positions and reset values.
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

`define GPC_PINS 3
`define GPC_ADDR_W 32
`define GPC_DATA_W 32
`define GPC_OFF_W 6
`define GPC_BASE 32'h400C_0200
`define GPC_WIN_MASK 32'hFFFF_FFC0
`define GPC_OFF_DATA 6'h00
`define GPC_OFF_OE 6'h04
`define GPC_OFF_SER 6'h08
`define GPC_OFF_TMR 6'h10
`define GPC_OFF_FLOW 6'h14
`define GPC_OFF_OD 6'h28
`define GPC_OFF_PU 6'h2C
`define GPC_OFF_IE 6'h38
`define GPC_RST_PINS 3'h0
`define GPC_RST_WORD 32'h0000_0000
`define GPC_PIN_TX 0
`define GPC_PIN_CAP0 0
`define GPC_PIN_RX 1
`define GPC_PIN_CAP1 1
`define GPC_PIN_SCLK 2
`define GPC_PIN_TOUT 2
`define GPC_PIN_CTS 2

`endif

// [gpc_pkg.sv]
// Types shared by the three-bit port modules.
`default_nettype none
`include "gpc_cfg.svh"
package gpc_pkg;

	typedef logic [`GPC_PINS-1:0] gpc_pins_t;
	typedef logic [`GPC_ADDR_W-1:0] gpc_addr_t;
	typedef logic [`GPC_DATA_W-1:0] gpc_word_t;

	// Register selected by a bus address.
	typedef enum logic [3:0] {
		GPC_R_NONE = 4'b0000,
		GPC_R_DATA = 4'b0001,
		GPC_R_OE = 4'b0010,
		GPC_R_SER = 4'b0011,
		GPC_R_TMR = 4'b0100,
		GPC_R_FLOW = 4'b0101,
		GPC_R_OD = 4'b0110,
		GPC_R_PU = 4'b0111,
		GPC_R_IE = 4'b1000
	} gpc_reg_e;

endpackage
`default_nettype wire

// [gpc_pin_sync.sv]
// Two-stage input synchroniser for the port pins, gated by the input enables.
`timescale 1ns/10ps
`default_nettype none
`include "gpc_cfg.svh"
module gpc_pin_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire gpc_pkg::gpc_pins_t pin_in,
	input wire gpc_pkg::gpc_pins_t input_enable,
	output logic [`GPC_PINS-1:0] pins_sampled
);
	import gpc_pkg::*;

	typedef struct packed {
		gpc_pins_t meta;
		gpc_pins_t stable;
	} gpc_sync_s;

	gpc_sync_s st;
	gpc_sync_s next_st;

	// The first stage feeds only the second stage.
	always_comb
	begin
		next_st = st;
		next_st.meta = pin_in;
		next_st.stable = st.meta;
	end

	// State register.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// A disabled input buffer presents zero downstream.
	assign pins_sampled = st.stable & input_enable;

endmodule
`default_nettype wire

// [gpc_pad_drive.sv]
// Output stage of the port pins: push-pull or open-drain drive, registered.
`timescale 1ns/10ps
`default_nettype none
`include "gpc_cfg.svh"
module gpc_pad_drive (
	input wire logic clk,
	input wire logic rstn,
	input wire gpc_pkg::gpc_pins_t drive_en,
	input wire gpc_pkg::gpc_pins_t drive_val,
	input wire gpc_pkg::gpc_pins_t open_drain,
	output logic [`GPC_PINS-1:0] pin_out,
	output logic [`GPC_PINS-1:0] pin_oe
);
	import gpc_pkg::*;

	typedef struct packed {
		gpc_pins_t out;
		gpc_pins_t oe;
	} gpc_pad_s;

	gpc_pad_s st;
	gpc_pad_s next_st;

	// Open drain only ever pulls low and releases the pin for a one.
	always_comb
	begin
		next_st = st;
		next_st.out = drive_val & ~open_drain;
		next_st.oe = drive_en & (~open_drain | ~drive_val);
	end

	// State register.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign pin_out = st.out;
	assign pin_oe = st.oe;

endmodule
`default_nettype wire

// [gpc_port.sv]
// Three-bit general-purpose port with register file and alternate function routing.
//
// Operation
// - Registers decoded at fixed base plus offsets.
// - Data register: three bits, upper bits zero.
// - Output control bit one enables pin driver.
// - Serial select routes clock, receive, transmit.
// - Timer select routes timer output, two captures.
// - Flow select has only bit two, clear-to-send.
// - Open-drain bit one selects open drain.
// - Pull-up bit one enables pin pull-up.
// - Input control register at its own offset.
// - Input bit one enables pin input buffer.
// - Reset clears every control register to zero.
`timescale 1ns/10ps
`default_nettype none
`include "gpc_cfg.svh"
module gpc_port (
	input wire logic clk,
	input wire logic rstn,
	input wire gpc_pkg::gpc_addr_t bus_addr,
	input wire gpc_pkg::gpc_word_t bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [`GPC_DATA_W-1:0] bus_rdata,
	input wire gpc_pkg::gpc_pins_t pin_in,
	output logic [`GPC_PINS-1:0] pin_out,
	output logic [`GPC_PINS-1:0] pin_oe,
	output logic [`GPC_PINS-1:0] pin_pullup,
	input wire logic serial1_transmit,
	input wire logic serial1_clock_out,
	input wire logic serial1_clock_drive,
	output logic serial1_clock,
	output logic serial1_receive,
	output logic serial1_clear_to_send,
	input wire logic timer0_output,
	output logic timer2_capture_in0,
	output logic timer2_capture_in1
);
	import gpc_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------

	typedef struct packed {
		gpc_pins_t data;
		gpc_pins_t oe;
		gpc_pins_t ser_sel;
		gpc_pins_t tmr_sel;
		logic flow_sel;
		gpc_pins_t od;
		gpc_pins_t pu;
		gpc_pins_t ie;
		gpc_word_t rdata;
	} gpc_port_s;

	gpc_port_s st;
	gpc_port_s next_st;
	gpc_reg_e acc_reg;
	gpc_pins_t sampled;
	gpc_pins_t pin_view;
	gpc_pins_t drive_en;
	gpc_pins_t drive_val;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------

	// Maps a bus address to a register; anything outside the map is none.
	function automatic gpc_reg_e reg_decode(input gpc_addr_t addr);
		logic [`GPC_OFF_W-1:0] off;
		off = addr[`GPC_OFF_W-1:0];
		reg_decode = GPC_R_NONE;
		if ((addr & `GPC_WIN_MASK) == `GPC_BASE)
		begin
			case (off)
				`GPC_OFF_DATA: reg_decode = GPC_R_DATA;
				`GPC_OFF_OE: reg_decode = GPC_R_OE;
				`GPC_OFF_SER: reg_decode = GPC_R_SER;
				`GPC_OFF_TMR: reg_decode = GPC_R_TMR;
				`GPC_OFF_FLOW: reg_decode = GPC_R_FLOW;
				`GPC_OFF_OD: reg_decode = GPC_R_OD;
				`GPC_OFF_PU: reg_decode = GPC_R_PU;
				`GPC_OFF_IE: reg_decode = GPC_R_IE;
				default: reg_decode = GPC_R_NONE;
			endcase
		end
	endfunction

	// Places a three-bit field in the low bits of a word.
	function automatic gpc_word_t pins_word(input gpc_pins_t v);
		pins_word = `GPC_RST_WORD;
		pins_word[`GPC_PINS-1:0] = v;
	endfunction

	assign acc_reg = reg_decode(bus_addr);

	// ------------------------------------------------------------
	// Input path
	// ------------------------------------------------------------

	// Pins are synchronised and masked by the input enables.
	gpc_pin_sync u_sync (
		.clk(clk),
		.rstn(rstn),
		.pin_in(pin_in),
		.input_enable(st.ie),
		.pins_sampled(sampled)
	);

	// An enabled pin reads its level; a disabled one reads the data latch.
	assign pin_view = (sampled & st.ie) | (st.data & ~st.ie);

	// Input alternate functions receive the gated pin level.
	assign serial1_receive = sampled[`GPC_PIN_RX] & st.ser_sel[`GPC_PIN_RX];
	assign serial1_clock = sampled[`GPC_PIN_SCLK] & st.ser_sel[`GPC_PIN_SCLK];
	assign serial1_clear_to_send = sampled[`GPC_PIN_CTS] & st.flow_sel;
	assign timer2_capture_in0 = sampled[`GPC_PIN_CAP0] & st.tmr_sel[`GPC_PIN_CAP0];
	assign timer2_capture_in1 = sampled[`GPC_PIN_CAP1] & st.tmr_sel[`GPC_PIN_CAP1];

	// ------------------------------------------------------------
	// Output routing
	// ------------------------------------------------------------

	// Chooses driver value and enable per pin. Output functions need the
	// output control bit; input-only functions turn the driver off so the
	// latch cannot fight the external source. Serial wins over timer, which
	// wins over flow control, if software selects more than one.
	always_comb
	begin
		drive_val = st.data;
		drive_en = st.oe;
		if (st.ser_sel[`GPC_PIN_TX])
		begin
			drive_val[`GPC_PIN_TX] = serial1_transmit;
		end
		else if (st.tmr_sel[`GPC_PIN_CAP0])
		begin
			drive_en[`GPC_PIN_CAP0] = 1'b0;
		end
		if (st.ser_sel[`GPC_PIN_RX] | st.tmr_sel[`GPC_PIN_CAP1])
		begin
			drive_en[`GPC_PIN_RX] = 1'b0;
		end
		if (st.ser_sel[`GPC_PIN_SCLK])
		begin
			drive_val[`GPC_PIN_SCLK] = serial1_clock_out;
			drive_en[`GPC_PIN_SCLK] = st.oe[`GPC_PIN_SCLK] & serial1_clock_drive;
		end
		else if (st.tmr_sel[`GPC_PIN_TOUT])
		begin
			drive_val[`GPC_PIN_TOUT] = timer0_output;
		end
		else if (st.flow_sel)
		begin
			drive_en[`GPC_PIN_CTS] = 1'b0;
		end
	end

	// Registered pad stage, push-pull or open drain per pin.
	gpc_pad_drive u_pad (
		.clk(clk),
		.rstn(rstn),
		.drive_en(drive_en),
		.drive_val(drive_val),
		.open_drain(st.od),
		.pin_out(pin_out),
		.pin_oe(pin_oe)
	);

	assign pin_pullup = st.pu;

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------

	// Writes update one register; reads present data the next cycle only.
	always_comb
	begin
		next_st = st;
		next_st.rdata = `GPC_RST_WORD;
		if (bus_wr)
		begin
			case (acc_reg)
				GPC_R_DATA: next_st.data = bus_wdata[`GPC_PINS-1:0];
				GPC_R_OE: next_st.oe = bus_wdata[`GPC_PINS-1:0];
				GPC_R_SER: next_st.ser_sel = bus_wdata[`GPC_PINS-1:0];
				GPC_R_TMR: next_st.tmr_sel = bus_wdata[`GPC_PINS-1:0];
				GPC_R_FLOW: next_st.flow_sel = bus_wdata[`GPC_PIN_CTS];
				GPC_R_OD: next_st.od = bus_wdata[`GPC_PINS-1:0];
				GPC_R_PU: next_st.pu = bus_wdata[`GPC_PINS-1:0];
				GPC_R_IE: next_st.ie = bus_wdata[`GPC_PINS-1:0];
				default: next_st.data = st.data;
			endcase
		end
		if (bus_rd)
		begin
			case (acc_reg)
				GPC_R_DATA: next_st.rdata = pins_word(pin_view);
				GPC_R_OE: next_st.rdata = pins_word(st.oe);
				GPC_R_SER: next_st.rdata = pins_word(st.ser_sel);
				GPC_R_TMR: next_st.rdata = pins_word(st.tmr_sel);
				GPC_R_FLOW: next_st.rdata[`GPC_PIN_CTS] = st.flow_sel;
				GPC_R_OD: next_st.rdata = pins_word(st.od);
				GPC_R_PU: next_st.rdata = pins_word(st.pu);
				GPC_R_IE: next_st.rdata = pins_word(st.ie);
				default: next_st.rdata = `GPC_RST_WORD;
			endcase
		end
	end

	// Reset leaves every pin a plain port pin with all buffers off.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st.data <= `GPC_RST_PINS;
			st.oe <= `GPC_RST_PINS;
			st.ser_sel <= `GPC_RST_PINS;
			st.tmr_sel <= `GPC_RST_PINS;
			st.flow_sel <= 1'b0;
			st.od <= `GPC_RST_PINS;
			st.pu <= `GPC_RST_PINS;
			st.ie <= `GPC_RST_PINS;
			st.rdata <= `GPC_RST_WORD;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign bus_rdata = st.rdata;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// A read outside the map answers zero.
	a_unmapped_read_zero: assert property (
		bus_rd && reg_decode(bus_addr) == GPC_R_NONE |=> bus_rdata == `GPC_RST_WORD)
		else $error("unmapped read did not return zero");

	// Bits above the pin field never read as one.
	a_upper_bits_zero: assert property (
		bus_rdata[`GPC_DATA_W-1:`GPC_PINS] == '0)
		else $error("reserved read data bits not zero");

	// The flow select reads zero in its two low bits.
	a_flow_low_zero: assert property (
		bus_rd && bus_addr == (`GPC_BASE | `GPC_OFF_FLOW) |=> bus_rdata[1:0] == 2'h0)
		else $error("flow select low bits not zero");

	// Data written with input off reads back unchanged.
	a_data_readback: assert property (
		bus_wr && bus_addr == (`GPC_BASE | `GPC_OFF_DATA) && st.ie == '0 ##1
		bus_rd && bus_addr == (`GPC_BASE | `GPC_OFF_DATA) && !bus_wr
		|=> bus_rdata[`GPC_PINS-1:0] == $past(bus_wdata[`GPC_PINS-1:0], 2))
		else $error("data register readback mismatch");

	// The input control register reads back its own state.
	a_ie_readback: assert property (
		bus_rd && bus_addr == (`GPC_BASE | `GPC_OFF_IE) |=> bus_rdata[`GPC_PINS-1:0] == $past(st.ie))
		else $error("input control readback mismatch");

	// A pull-up write reaches the pin control one cycle later.
	a_pullup_write: assert property (
		bus_wr && bus_addr == (`GPC_BASE | `GPC_OFF_PU) |=> pin_pullup == $past(bus_wdata[`GPC_PINS-1:0]))
		else $error("pull-up did not follow write");

	// With outputs disabled for two cycles no pin is driven.
	a_no_drive_off: assert property (
		st.oe == '0 [*2] |-> pin_oe == '0)
		else $error("pin driven while output disabled");

	// Open drain never drives a high level.
	a_od_never_high: assert property (
		$past(st.od) != '0 |-> (pin_oe & pin_out & $past(st.od)) == '0)
		else $error("open-drain pin driven high");

	// A plain port pin in push-pull drives its data bit.
	a_port_drives_data: assert property (
		st.oe[0] && !st.od[0] && !st.ser_sel[0] && !st.tmr_sel[0]
		|=> pin_oe[0] && pin_out[0] == $past(st.data[0]))
		else $error("port pin not driving data bit");

	// Transmit routing puts the serial line on pin zero.
	a_tx_routed: assert property (
		st.ser_sel[`GPC_PIN_TX] && st.oe[`GPC_PIN_TX] && !st.od[`GPC_PIN_TX]
		|=> pin_out[`GPC_PIN_TX] == $past(serial1_transmit))
		else $error("transmit not routed to pin");

	// A disabled input presents zero to the peripherals.
	a_input_gated: assert property (
		!st.ie[`GPC_PIN_RX] |-> !serial1_receive && !timer2_capture_in1)
		else $error("disabled input reached peripheral");

	// Receive routing releases the driver of its pin.
	a_rx_released: assert property (
		st.ser_sel[`GPC_PIN_RX] |=> !pin_oe[`GPC_PIN_RX])
		else $error("receive pin still driven");

	// The serial clock pin is driven only when the serial unit asks for it.
	a_sclk_drive_gated: assert property (
		st.ser_sel[`GPC_PIN_SCLK] && !serial1_clock_drive |=> !pin_oe[`GPC_PIN_SCLK])
		else $error("serial clock pin driven without request");

	// A capture input releases the driver of its pin.
	a_capture_released: assert property (
		st.tmr_sel[`GPC_PIN_CAP0] && !st.ser_sel[`GPC_PIN_CAP0] |=> !pin_oe[`GPC_PIN_CAP0])
		else $error("capture pin still driven");

	// Timer output routing puts the timer level on its pin.
	a_tout_routed: assert property (
		st.tmr_sel[`GPC_PIN_TOUT] && !st.ser_sel[`GPC_PIN_TOUT] && st.oe[`GPC_PIN_TOUT]
		&& !st.od[`GPC_PIN_TOUT]
		|=> pin_oe[`GPC_PIN_TOUT] && pin_out[`GPC_PIN_TOUT] == $past(timer0_output))
		else $error("timer output not routed to pin");

	// Clear-to-send stays low while its select is off.
	a_cts_gated: assert property (
		!st.flow_sel |-> !serial1_clear_to_send)
		else $error("clear-to-send active while not selected");

	// An input control write lands at the write edge.
	a_ie_write: assert property (
		bus_wr && bus_addr == (`GPC_BASE | `GPC_OFF_IE) |=> st.ie == $past(bus_wdata[`GPC_PINS-1:0]))
		else $error("input control write lost");

	// Read data stand only in the cycle after a read strobe.
	a_rdata_one_cycle: assert property (
		!bus_rd |=> bus_rdata == `GPC_RST_WORD)
		else $error("read data present without read strobe");

	// Main scenarios.
	c_open_drain_low: cover property ((st.od & pin_oe) != '0);
	c_timer_out: cover property (st.tmr_sel[`GPC_PIN_TOUT] && pin_oe[`GPC_PIN_TOUT]);
	c_rx_seen: cover property (serial1_receive);
	c_back_to_back: cover property (bus_wr ##1 bus_rd);

endmodule
`default_nettype wire

// [gpc_port_tb_top.sv]
// Self-checking bench of the three-bit port: register access, pin drive and routing.
`timescale 1ns/10ps
`default_nettype none
`include "gpc_cfg.svh"
module gpc_port_tb_top;
	import gpc_pkg::*;

	// ----------------------------------------
	// Signals and tables
	// ----------------------------------------
	logic clk;
	logic rstn;
	gpc_addr_t bus_addr;
	gpc_word_t bus_wdata;
	logic bus_wr;
	logic bus_rd;
	logic [`GPC_DATA_W-1:0] bus_rdata;
	gpc_pins_t pin_in;
	logic [`GPC_PINS-1:0] pin_out;
	logic [`GPC_PINS-1:0] pin_oe;
	logic [`GPC_PINS-1:0] pin_pullup;
	logic serial1_transmit;
	logic serial1_clock_out;
	logic serial1_clock_drive;
	logic serial1_clock;
	logic serial1_receive;
	logic serial1_clear_to_send;
	logic timer0_output;
	logic timer2_capture_in0;
	logic timer2_capture_in1;
	int error_cnt;
	int cmp_count;
	int cyc;
	gpc_word_t rd_word;
	logic [5:0] offs [8] = '{`GPC_OFF_DATA, `GPC_OFF_OE, `GPC_OFF_SER, `GPC_OFF_TMR,
		`GPC_OFF_FLOW, `GPC_OFF_OD, `GPC_OFF_PU, `GPC_OFF_IE};
	gpc_word_t masks [8] = '{32'h7, 32'h7, 32'h7, 32'h7, 32'h4, 32'h7, 32'h7, 32'h7};
	// Addresses outside the port's window; its own reserved offsets are never touched.
	gpc_addr_t bad [6] = '{`GPC_BASE - 32'h40, `GPC_BASE + 32'h40, `GPC_BASE + 32'h80,
		`GPC_BASE + 32'h100, `GPC_BASE + 32'h1000, `GPC_BASE ^ 32'h8000_0000};

	gpc_port dut (
		.clk(clk),
		.rstn(rstn),
		.bus_addr(bus_addr),
		.bus_wdata(bus_wdata),
		.bus_wr(bus_wr),
		.bus_rd(bus_rd),
		.bus_rdata(bus_rdata),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.pin_pullup(pin_pullup),
		.serial1_transmit(serial1_transmit),
		.serial1_clock_out(serial1_clock_out),
		.serial1_clock_drive(serial1_clock_drive),
		.serial1_clock(serial1_clock),
		.serial1_receive(serial1_receive),
		.serial1_clear_to_send(serial1_clear_to_send),
		.timer0_output(timer0_output),
		.timer2_capture_in0(timer2_capture_in0),
		.timer2_capture_in1(timer2_capture_in1)
	);

	// ----------------------------------------
	// Clock, timeout and tasks
	// ----------------------------------------
	// The clock toggles every half period of 50 ns.
	always #50 clk = ~clk;

	// A hung run counts as a mismatch and ends the test.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			error_cnt++;
			test_done();
		end
	end

	task automatic test_done();
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	function automatic gpc_addr_t ra(input logic [5:0] off);
		return `GPC_BASE + {26'h0, off};
	endfunction

	// Lets n edges pass, then waits until their updates have landed.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic bus_write(input gpc_addr_t a, input gpc_word_t d);
		@(posedge clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic bus_read(input gpc_addr_t a, output gpc_word_t d);
		@(posedge clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1;
		d = bus_rdata;
	endtask

	// Writes one address and reads it back in the very next cycle.
	task automatic wr_rd(input gpc_addr_t a, input gpc_word_t wd, output gpc_word_t d);
		@(posedge clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= wd;
		@(posedge clk);
		bus_wr <= 1'b0;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1;
		d = bus_rdata;
	endtask

	task automatic chk_word(input gpc_word_t got, input gpc_word_t exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t word got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_pins(input gpc_pins_t got, input gpc_pins_t exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t pins got %b exp %b", $time, got, exp);
		end
	endtask

	task automatic chk_rd(input gpc_addr_t a, input gpc_word_t exp);
		gpc_word_t d;
		bus_read(a, d);
		chk_word(d, exp);
	endtask

	// Drives the pins and the peripheral signals together at one edge.
	task automatic drive(input gpc_pins_t p, input logic tx, input logic co, input logic cd,
		input logic tm);
		@(posedge clk);
		pin_in <= p;
		serial1_transmit <= tx;
		serial1_clock_out <= co;
		serial1_clock_drive <= cd;
		timer0_output <= tm;
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	// Runs the scenarios one after another and ends with the verdict.
	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		bus_addr = '0;
		bus_wdata = '0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		pin_in = '0;
		serial1_transmit = 1'b0;
		serial1_clock_out = 1'b0;
		serial1_clock_drive = 1'b0;
		timer0_output = 1'b0;
		error_cnt = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 8; i++)
			chk_rd(ra(offs[i]), `GPC_RST_WORD);
		chk_pins(pin_oe | pin_out | pin_pullup, `GPC_RST_PINS);
		for (int i = 0; i < 8; i++)
		begin
			wr_rd(ra(offs[i]), 32'hFFFF_FFFF, rd_word);
			chk_word(rd_word, masks[i]);
			bus_write(ra(offs[i]), 32'h0);
		end
		bus_write(ra(`GPC_OFF_DATA), 32'h2);
		for (int i = 0; i < 6; i++)
		begin
			bus_write(bad[i], 32'hFFFF_FFFF);
			chk_rd(bad[i], 32'h0);
		end
		chk_rd(ra(`GPC_OFF_DATA), 32'h2);
		bus_write(ra(`GPC_OFF_PU), 32'h5);
		tick(3);
		chk_pins(pin_pullup, 3'h5);
		bus_write(ra(`GPC_OFF_OE), 32'h7);
		bus_write(ra(`GPC_OFF_DATA), 32'h5);
		tick(3);
		chk_pins(pin_oe, 3'h7);
		chk_pins(pin_out, 3'h5);
		bus_write(ra(`GPC_OFF_OD), 32'h7);
		tick(3);
		chk_pins(pin_out, 3'h0);
		chk_pins(pin_oe, 3'h2);
		bus_write(ra(`GPC_OFF_OD), 32'h0);
		drive(3'h6, 1'b0, 1'b0, 1'b1, 1'b0);
		chk_rd(ra(`GPC_OFF_DATA), 32'h5);
		bus_write(ra(`GPC_OFF_IE), 32'h7);
		tick(3);
		chk_rd(ra(`GPC_OFF_DATA), 32'h6);
		bus_write(ra(`GPC_OFF_SER), 32'h7);
		tick(3);
		chk_pins(pin_oe, 3'h5);
		chk_pins(pin_out & 3'h5, 3'h0);
		chk_pins({1'b0, serial1_clock, serial1_receive}, 3'h3);
		drive(3'h6, 1'b1, 1'b1, 1'b0, 1'b0);
		tick(3);
		chk_pins(pin_oe, 3'h1);
		chk_pins(pin_out & 3'h1, 3'h1);
		drive(3'h6, 1'b1, 1'b1, 1'b1, 1'b0);
		tick(3);
		chk_pins(pin_out, 3'h5);
		chk_pins(pin_oe, 3'h5);
		bus_write(ra(`GPC_OFF_IE), 32'h3);
		tick(3);
		chk_pins({2'b0, serial1_clock}, 3'h0);
		bus_write(ra(`GPC_OFF_IE), 32'h7);
		bus_write(ra(`GPC_OFF_SER), 32'h0);
		bus_write(ra(`GPC_OFF_TMR), 32'h7);
		drive(3'h3, 1'b0, 1'b0, 1'b0, 1'b0);
		tick(3);
		chk_pins(pin_oe, 3'h4);
		chk_pins(pin_out & 3'h4, 3'h0);
		chk_pins({serial1_receive, timer2_capture_in1, timer2_capture_in0}, 3'h3);
		drive(3'h0, 1'b0, 1'b0, 1'b0, 1'b1);
		tick(3);
		chk_pins(pin_out & 3'h4, 3'h4);
		chk_pins({1'b0, timer2_capture_in1, timer2_capture_in0}, 3'h0);
		bus_write(ra(`GPC_OFF_TMR), 32'h0);
		bus_write(ra(`GPC_OFF_FLOW), 32'h4);
		drive(3'h4, 1'b0, 1'b0, 1'b0, 1'b0);
		tick(3);
		chk_pins({serial1_clock, serial1_clear_to_send, 1'b0}, 3'h2);
		chk_pins(pin_oe, 3'h3);
		@(posedge clk);
		rstn <= 1'b0;
		tick(2);
		chk_pins(pin_oe | pin_pullup, 3'h0);
		chk_pins({2'b0, serial1_clear_to_send}, 3'h0);
		@(posedge clk);
		rstn <= 1'b1;
		chk_rd(ra(`GPC_OFF_FLOW), 32'h0);
		chk_rd(ra(`GPC_OFF_PU), 32'h0);
		test_done();
	end
endmodule
`default_nettype wire
